/* rtl/emsync_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "emsync_cfg.svh"

module emsync_sync3 #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  // a bit only moves once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      dout  <= '0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      dout  <= (s2_ff & ~(s2_ff ^ s3_ff)) | (dout & (s2_ff ^ s3_ff));
    end
  end
endmodule

module emsync_top
  import emsync_pkg::*;
#(
  parameter int HOLDOFF_CYC = `EMS_HOLDOFF_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        emulation_sync_line_in,
  output logic             emulation_sync_line_out,
  output logic             emulation_sync_line_oe_n,
  input  wire logic        trace_sync_line_in,
  output logic             trace_sync_line_out,
  output logic             trace_sync_line_oe_n,
  input  wire logic        addr_latch_strobe,
  input  wire logic [7:0]  target_port0,
  input  wire logic [7:0]  target_port1,
  input  wire logic [7:0]  target_port2,
  input  wire logic        target_vcc_ok,
  input  wire logic        target_clk_alive,
  input  wire logic        target_reset_pin,
  input  wire logic        break_req,
  input  wire logic        breakpoint_zero_hit,
  input  wire logic        breakpoint_one_hit,
  input  wire logic        irq_at_break,
  input  wire logic        qualify_event,
  input  wire logic        timer_running,
  output logic             timer_extra_count,
  output logic             trace_wr,
  output logic [23:0]      trace_data,
  output logic             emulating,
  output logic             lamp_red,
  output logic             lamp_green,
  output logic             lamp_yellow
);
  localparam logic [23:0] HOLD_LOAD = 24'(HOLDOFF_CYC - 1);

  // bus and register state
  logic                    wr_pend_ff;
  logic [7:0]              wr_addr_ff;
  logic [`EMS_CTRL_W-1:0]  ctrl_ff;
  logic [15:0]             bp0_addr_ff;
  logic [15:0]             bp1_addr_ff;
  logic [31:0]             rdata_ff;
  logic [8:0]              cmd;
  logic [2:0]              errclr;
  // target side
  logic [29:0]             pins;
  logic                    ale_prev_ff;
  logic                    ale_rise;
  logic                    emu_lat_ff;
  logic                    trc_lat_ff;
  logic                    emu_eff;
  logic                    trc_eff;
  logic                    emu_in_en;
  logic                    trc_in_en;
  // emulation and trace control
  emsync_emu_e             state_ff;
  emsync_emu_e             nxt_state;
  logic [23:0]             hold_cnt_ff;
  logic                    seen_high_ff;
  logic                    tracing_ff;
  logic                    busy_ff;
  logic                    hw_err_ff;
  logic                    recovered_ff;
  logic [4:0]              reinit_cnt_ff;
  logic [2:0]              err_ff;
  logic                    err_report_ff;
  logic [1:0]              cause_ff;
  logic                    qual_seen_ff;
  logic [2:0]              extra_cnt_ff;
  logic                    brk;
  logic                    running;
  logic                    near;
  logic [16:0]             bp_diff;

  assign running = (state_ff == EMS_RUN);
  assign brk     = running && break_req;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;
  assign emulating = running;
  assign emulation_sync_line_out = 1'b0;
  assign trace_sync_line_out     = 1'b0;

  // address phase captured, write data applied one cycle later
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= hsel && hready && htrans[1] && hwrite;
      wr_addr_ff <= haddr;
    end
  end

  assign cmd    = (wr_pend_ff && wr_addr_ff == `EMS_CMD_OFS) ?
                  hwdata[8:0] : 9'h000;
  assign errclr = (wr_pend_ff && wr_addr_ff == `EMS_STATUS_OFS) ?
                  hwdata[`EMS_S_RST:`EMS_S_VCC] : 3'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff     <= `EMS_CTRL_RST;
      bp0_addr_ff <= 16'h0000;
      bp1_addr_ff <= 16'h0000;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == `EMS_CTRL_OFS)
        ctrl_ff <= hwdata[`EMS_CTRL_W-1:0];
      if (wr_addr_ff == `EMS_BP0_OFS)
        bp0_addr_ff <= hwdata[15:0];
      if (wr_addr_ff == `EMS_BP1_OFS)
        bp1_addr_ff <= hwdata[15:0];
    end
  end

  // read data loaded in the address phase so it stands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr)
        `EMS_CTRL_OFS:   rdata_ff <= {23'h000000, ctrl_ff};
        `EMS_STATUS_OFS: rdata_ff <= {17'h00000, cause_ff, err_report_ff,
                                      err_ff, lamp_yellow, lamp_green,
                                      lamp_red, seen_high_ff, trc_eff,
                                      emu_eff, state_ff == EMS_ARM,
                                      tracing_ff, running};
        `EMS_BP0_OFS:    rdata_ff <= {16'h0000, bp0_addr_ff};
        `EMS_BP1_OFS:    rdata_ff <= {16'h0000, bp1_addr_ff};
        default:         rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // all target pins cross into hclk through three stages
  emsync_sync3 #(.W(30)) u_pins (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     ({emulation_sync_line_in, trace_sync_line_in,
               addr_latch_strobe, target_vcc_ok, target_clk_alive,
               target_reset_pin, target_port2, target_port1,
               target_port0}),
    .dout    (pins)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ale_prev_ff <= 1'b0;
    else
      ale_prev_ff <= pins[27];
  end
  assign ale_rise = pins[27] && !ale_prev_ff;

  // latched mode samples on strobe rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      emu_lat_ff <= 1'b1;
      trc_lat_ff <= 1'b1;
    end else if (ale_rise) begin
      emu_lat_ff <= pins[29];
      trc_lat_ff <= pins[28];
    end
  end

  assign emu_in_en = ctrl_ff[`EMS_C_EMU_LVL] || ctrl_ff[`EMS_C_EMU_LAT];
  assign trc_in_en = ctrl_ff[`EMS_C_TRC_LVL] || ctrl_ff[`EMS_C_TRC_LAT];
  assign emu_eff = ctrl_ff[`EMS_C_EMU_LAT] ? emu_lat_ff : pins[29];
  assign trc_eff = ctrl_ff[`EMS_C_TRC_LAT] ? trc_lat_ff : pins[28];

  // emulation run control
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      EMS_IDLE:
        if (cmd[`EMS_K_RUN])
          nxt_state = emu_in_en ? EMS_ARM : EMS_RUN;
      EMS_ARM:
        if (cmd[`EMS_K_HALT])
          nxt_state = EMS_IDLE;
        // start after holdoff once line is high
        else if (hold_cnt_ff == 24'h000000 && emu_eff)
          nxt_state = EMS_RUN;
      EMS_RUN:
        if (cmd[`EMS_K_HALT] || brk || (emu_in_en && !emu_eff))
          nxt_state = EMS_IDLE;
      default:
        nxt_state = EMS_IDLE;
    endcase
    if (cmd[`EMS_K_REINIT])
      nxt_state = EMS_IDLE;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      state_ff <= EMS_IDLE;
    else
      state_ff <= nxt_state;
  end

  // half second holdoff from run command
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      hold_cnt_ff <= 24'h000000;
    else if (state_ff == EMS_IDLE && cmd[`EMS_K_RUN])
      hold_cnt_ff <= HOLD_LOAD;
    else if (hold_cnt_ff != 24'h000000)
      hold_cnt_ff <= hold_cnt_ff - 24'h000001;
  end

  // remembers whether the line was high while input was on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      seen_high_ff <= 1'b0;
    else if (emu_in_en && emu_eff)
      seen_high_ff <= 1'b1; // a high in the reinit cycle still counts
    else if (cmd[`EMS_K_REINIT])
      seen_high_ff <= 1'b0;
  end

  // trace follows its line when input is on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      tracing_ff <= 1'b0;
    else if (cmd[`EMS_K_REINIT])
      tracing_ff <= 1'b0;
    else if (trc_in_en)
      tracing_ff <= trc_eff;
    else if (cmd[`EMS_K_TSTART])
      tracing_ff <= 1'b1;
    else if (cmd[`EMS_K_TSTOP])
      tracing_ff <= 1'b0;
  end

  // open drain, pulled low when stopped
  // far end must not fight the sink
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      emulation_sync_line_oe_n <= 1'b1;
      trace_sync_line_oe_n     <= 1'b1;
    end else begin
      emulation_sync_line_oe_n <= !(ctrl_ff[`EMS_C_EMU_OUT] &&
                                    nxt_state != EMS_RUN);
      trace_sync_line_oe_n     <= !(ctrl_ff[`EMS_C_TRC_OUT] && !tracing_ff);
    end
  end

  // losses are only noted while running, reported at break
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      err_ff        <= 3'h0;
      err_report_ff <= 1'b0;
    end else begin
      err_ff[0] <= (running && !pins[26]) || (err_ff[0] && !errclr[0]);
      err_ff[1] <= (running && !pins[25]) || (err_ff[1] && !errclr[1]);
      err_ff[2] <= (!running && pins[24]) || (err_ff[2] && !errclr[2]);
      if (brk)
        err_report_ff <= err_ff[0] || err_ff[1];
      else if (cmd[`EMS_K_RUN])
        err_report_ff <= 1'b0;
    end
  end

  assign bp_diff = {1'b0, bp0_addr_ff} - {1'b0, bp1_addr_ff};
  assign near = ((bp_diff[16] ? 17'(-bp_diff) : bp_diff) < `EMS_NEAR_DIST)
             || bp0_addr_ff[11:2] == 10'h000
             || bp1_addr_ff[11:2] == 10'h000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      cause_ff <= 2'b00;
    else if (brk)
      cause_ff <= {breakpoint_one_hit || (breakpoint_zero_hit && near),
                   breakpoint_zero_hit || (breakpoint_one_hit && near)};
  end

  // one extra timer count per break
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      timer_extra_count <= 1'b0;
    else
      timer_extra_count <= brk && timer_running;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      qual_seen_ff <= 1'b0;
    else if (!tracing_ff)
      qual_seen_ff <= 1'b0;
    else if (qualify_event)
      qual_seen_ff <= 1'b1;
  end

  // interrupt at break appends four frames
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      extra_cnt_ff <= 3'h0;
    else if (brk && irq_at_break && tracing_ff &&
             (ctrl_ff[`EMS_C_QUAL] || ctrl_ff[`EMS_C_AFTER]))
      extra_cnt_ff <= `EMS_EXTRA_FRAMES;
    else if (ale_rise && extra_cnt_ff != 3'h0)
      extra_cnt_ff <= extra_cnt_ff - 3'h1;
  end

  // frames hold ports 0 to 2 only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trace_wr   <= 1'b0;
      trace_data <= 24'h000000;
    end else begin
      trace_wr <= ale_rise && ((extra_cnt_ff != 3'h0) || (tracing_ff &&
                  (!ctrl_ff[`EMS_C_QUAL] || qual_seen_ff ||
                   (ctrl_ff[`EMS_C_SLOW] && qualify_event))));
      if (ale_rise)
        trace_data <= pins[23:0];
    end
  end

  // software-owned busy and error status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_ff       <= 1'b0;
      hw_err_ff     <= 1'b0;
      recovered_ff  <= 1'b0;
      reinit_cnt_ff <= 5'h00;
    end else begin
      busy_ff <= cmd[`EMS_K_BUSY] || (busy_ff && !cmd[`EMS_K_DONE]);
      hw_err_ff <= cmd[`EMS_K_HWERR] ||
                   (hw_err_ff && !cmd[`EMS_K_RECOVER]);
      if (cmd[`EMS_K_RECOVER] && hw_err_ff)
        recovered_ff <= 1'b1;
      else if (cmd[`EMS_K_BUSY] || cmd[`EMS_K_RUN])
        recovered_ff <= 1'b0;
      if (cmd[`EMS_K_REINIT])
        reinit_cnt_ff <= 5'(`EMS_REINIT_CYC);
      else if (reinit_cnt_ff != 5'h00)
        reinit_cnt_ff <= reinit_cnt_ff - 5'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lamp_red    <= 1'b0;
      lamp_green  <= 1'b0;
      lamp_yellow <= 1'b1;
    end else if (hw_err_ff) begin
      lamp_red    <= 1'b1;
      lamp_green  <= 1'b0;
      lamp_yellow <= 1'b0;
    end else if (reinit_cnt_ff != 5'h00 || recovered_ff) begin
      lamp_red    <= 1'b1;
      lamp_green  <= 1'b0;
      lamp_yellow <= 1'b1;
    end else begin
      lamp_red    <= 1'b0;
      lamp_green  <= running || state_ff == EMS_ARM;
      lamp_yellow <= running || (state_ff == EMS_IDLE && !busy_ff);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  emu_low_a: assert property (
    $fell(running) && ctrl_ff[`EMS_C_EMU_OUT] |-> !emulation_sync_line_oe_n)
    else $error("emulation line not pulled low at halt");
  emu_rel_a: assert property (
    $rose(running) |-> emulation_sync_line_oe_n)
    else $error("emulation line not released at start");
  hold_time_a: assert property (
    (state_ff == EMS_ARM) ##1 running |-> $past(hold_cnt_ff) == 24'h000000)
    else $error("run began before holdoff");
  trc_out_a: assert property (
    ctrl_ff[`EMS_C_TRC_OUT] && !tracing_ff |=> !trace_sync_line_oe_n)
    else $error("trace line not low while stopped");
  trc_rel_a: assert property (
    $rose(tracing_ff) |=> trace_sync_line_oe_n)
    else $error("trace line not released");
  halt_in_a: assert property (
    running && emu_in_en && !emu_eff |=> !running)
    else $error("low input did not halt");
  start_in_a: assert property (
    state_ff == EMS_ARM && hold_cnt_ff == 24'h000000 && emu_eff &&
    !cmd[`EMS_K_HALT] && !cmd[`EMS_K_REINIT] |=> running)
    else $error("high input did not start");
  trc_in_a: assert property (
    trc_in_en && !cmd[`EMS_K_REINIT] |=> tracing_ff == $past(trc_eff))
    else $error("trace did not follow input");
  wait_lamp_a: assert property (
    state_ff == EMS_ARM && !hw_err_ff && !recovered_ff &&
    reinit_cnt_ff == 5'h00 |=> lamp_green && !lamp_red)
    else $error("wait lamp wrong");
  run_lamp_a: assert property (
    running && !hw_err_ff && !recovered_ff && reinit_cnt_ff == 5'h00
    |=> lamp_green && lamp_yellow && !lamp_red)
    else $error("run lamps wrong");
  timer_tick_a: assert property (
    brk && timer_running |=> timer_extra_count ##1 !timer_extra_count)
    else $error("timer extra count missing");

  run_cover_c: cover property ($rose(running) ##[1:20] $fell(running));
  arm_cover_c: cover property (state_ff == EMS_ARM ##1 running);
  frame_cover_c: cover property (trace_wr && extra_cnt_ff != 3'h0);
endmodule
`default_nettype wire

/* rtl/emsync_cfg.svh */
// Summary of operation
// - emulation line tracks run, trace line tracks trace
// - output on: line low one cycle after halt
// - output on: line released one cycle after start
// - input on: half second from run to high
// - output on: trace line low when trace stops
// - output on: trace line high when trace starts
// - input low halts emulation within five cycles in level mode
// - input high starts emulation within 200 us
// - trace input low stops, high starts trace
// - latched mode samples inputs on strobe rising edge
// - run waits for first high, green lamp only
// - lamps: yellow idle, none busy, green-yellow run
// - red-yellow after recovery and during reinit
// - supply or clock loss reported at next break
// - capture ports zero to two, never port three
// - qualified trace starts frame after qualifying event
// - break cause may flag both near breakpoints
// - interrupt at break appends four extra frames
// - running timers gain one count per break
`ifndef EMSYNC_CFG_SVH
`define EMSYNC_CFG_SVH

// register byte offsets
`define EMS_CTRL_OFS     8'h00
`define EMS_CMD_OFS      8'h04
`define EMS_STATUS_OFS   8'h08
`define EMS_BP0_OFS      8'h0C
`define EMS_BP1_OFS      8'h10

// control register fields
`define EMS_C_EMU_OUT    0
`define EMS_C_EMU_LVL    1
`define EMS_C_EMU_LAT    2
`define EMS_C_TRC_OUT    3
`define EMS_C_TRC_LVL    4
`define EMS_C_TRC_LAT    5
`define EMS_C_QUAL       6
`define EMS_C_AFTER      7
`define EMS_C_SLOW       8
`define EMS_CTRL_W       9
`define EMS_CTRL_RST     9'h000

// command register fields (write-only pulses)
`define EMS_K_RUN        0
`define EMS_K_HALT       1
`define EMS_K_TSTART     2
`define EMS_K_TSTOP      3
`define EMS_K_REINIT     4
`define EMS_K_BUSY       5
`define EMS_K_DONE       6
`define EMS_K_HWERR      7
`define EMS_K_RECOVER    8

// status sticky error fields, write one to clear
`define EMS_S_VCC        9
`define EMS_S_CLK        10
`define EMS_S_RST        11

// timing
`define EMS_CLK_NS       100
`define EMS_HOLDOFF_MS   500
`define EMS_HOLDOFF_CYC  ((`EMS_HOLDOFF_MS * 1000000) / `EMS_CLK_NS)
`define EMS_REINIT_CYC   16
`define EMS_EXTRA_FRAMES 3'h4
`define EMS_NEAR_DIST    17'h00005

`endif

/* rtl/emsync_pkg.sv */
package emsync_pkg;
  typedef enum logic [1:0] {
    EMS_IDLE = 2'b00,
    EMS_ARM  = 2'b01,
    EMS_RUN  = 2'b10
  } emsync_emu_e;
endpackage

/* tb/emsync_far_end.sv */
`timescale 1ns/100ps
`default_nettype none
module emsync_far_end #(
  parameter int LOW_HOLD = 16
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic emu_oe_n,
  input  wire logic emu_out,
  input  wire logic trc_oe_n,
  input  wire logic trc_out,
  input  wire logic emu_req,
  input  wire logic trc_req,
  output logic      emu_line,
  output logic      trc_line
);
  logic       emu_low_ff;
  logic       trc_low_ff;
  logic [7:0] emu_cnt_ff;
  logic [7:0] trc_cnt_ff;

  // emulation low hold
  // a pull lasts LOW_HOLD+1 cycles past the request, so short pulses survive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      emu_low_ff <= 1'b0;
      emu_cnt_ff <= 8'h00;
    end else if (emu_req) begin
      emu_low_ff <= 1'b1;
      emu_cnt_ff <= 8'h00;
    end else if (emu_cnt_ff < 8'(LOW_HOLD)) begin
      emu_cnt_ff <= emu_cnt_ff + 8'h01;
    end else begin
      emu_low_ff <= 1'b0;
    end
  end

  // trace line pull, same hold as the emulation line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trc_low_ff <= 1'b0;
      trc_cnt_ff <= 8'h00;
    end else if (trc_req) begin
      trc_low_ff <= 1'b1;
      trc_cnt_ff <= 8'h00;
    end else if (trc_cnt_ff < 8'(LOW_HOLD)) begin
      trc_cnt_ff <= trc_cnt_ff + 8'h01;
    end else begin
      trc_low_ff <= 1'b0;
    end
  end

  // open collector wires
  // we only ever sink; a released line goes to the pull-up level
  assign emu_line = ((!emu_oe_n && !emu_out) || emu_low_ff) ? 1'b0 : 1'b1;
  assign trc_line = ((!trc_oe_n && !trc_out) || trc_low_ff) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* tb/emsync_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module emsync_top_bench;
  localparam int HOLD = 20;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic        emu_in, emu_out, emu_oe_n, trc_in, trc_out, trc_oe_n;
  logic        stb_en, emu_req, trc_req, vcc_ok, rst_pin, brk, bp0_hit;
  logic        tmr_run, timer_extra_count, trace_wr, emulating;
  logic        irq, qev, clk_ok;
  logic        lamp_red, lamp_green, lamp_yellow;
  logic [1:0]  stb_cnt;
  logic [2:0]  lamps;
  logic [23:0] ports, trace_data;
  int          err_total, compares, wn;

  assign lamps = {lamp_red, lamp_green, lamp_yellow};

  emsync_top #(
    .HOLDOFF_CYC(HOLD)
  ) u_emsync_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .emulation_sync_line_in(emu_in),
    .emulation_sync_line_out(emu_out),
    .emulation_sync_line_oe_n(emu_oe_n), .trace_sync_line_in(trc_in),
    .trace_sync_line_out(trc_out), .trace_sync_line_oe_n(trc_oe_n),
    .addr_latch_strobe(stb_cnt[1]), .target_port0(ports[7:0]),
    .target_port1(ports[15:8]), .target_port2(ports[23:16]),
    .target_vcc_ok(vcc_ok), .target_clk_alive(clk_ok),
    .target_reset_pin(rst_pin), .break_req(brk),
    .breakpoint_zero_hit(bp0_hit), .breakpoint_one_hit(1'b0),
    .irq_at_break(irq), .qualify_event(qev), .timer_running(tmr_run),
    .timer_extra_count(timer_extra_count), .trace_wr(trace_wr),
    .trace_data(trace_data), .emulating(emulating),
    .lamp_red(lamp_red), .lamp_green(lamp_green),
    .lamp_yellow(lamp_yellow)
  );

  emsync_far_end u_emsync_far_end (
    .hclk(hclk), .hresetn(hresetn), .emu_oe_n(emu_oe_n),
    .emu_out(emu_out), .trc_oe_n(trc_oe_n), .trc_out(trc_out),
    .emu_req(emu_req), .trc_req(trc_req), .emu_line(emu_in),
    .trc_line(trc_in)
  );

  // 10 MHz clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // target strobe, one processor cycle per four clocks; can be frozen
  always @(posedge hclk) begin
    if (stb_en) stb_cnt <= stb_cnt + 2'h1;
  end

  task automatic chk(input logic [31:0] seen, exp, input string msg);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return emulating;
      1: return trc_oe_n;
      2: return timer_extra_count;
      3: return trace_wr;
      default: return lamp_green;
    endcase
  endfunction

  // bounded wait; running out is a mismatch and ends the run
  task automatic wt(input int s, input logic v, input int b);
    wn = 0;
    while (pick(s) !== v) begin
      if (wn == b) begin
        err_total++;
        $display("[FAIL] %0t wait ran out", $time);
        stop_test;
      end
      @(posedge hclk);
      wn++;
    end
    compares++;
  endtask

  // one ahb phase: hold until hready is seen high at an edge
  task automatic hs;
    @(posedge hclk);
    for (int n = 0; hreadyout !== 1'b1; n++) begin
      if (n == 20) begin
        err_total++;
        $display("[FAIL] %0t bus hung", $time);
        stop_test;
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hs;
    htrans <= 2'h0;
    hwdata <= d;
    hs;
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdr(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // counts frame pulses over a window of c edges
  task automatic frames(input int c, input int e, input string m);
    int n;
    n = 0;
    repeat (c) begin
      @(posedge hclk);
      if (trace_wr === 1'b1) n++;
    end
    chk(n, e, m);
  endtask

  // reset state, control bits, unmapped place
  task automatic t_regs;
    chk(lamps, 3'h1, "idle lamps");
    chk({emu_oe_n, trc_oe_n}, 2'h3, "lines released");
    chk(hresp, 1'b0, "okay response");
    rdr(8'h00);
    chk(rd, 32'h0, "ctrl reset");
    wr(8'h00, 32'h1FF);
    rdr(8'h00);
    chk(rd, 32'h1FF, "ctrl readback");
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h8);
    wr(8'h40, 32'hFFFFFFFF);
    rdr(8'h40);
    chk(rd, 32'h0, "unmapped read");
    $display("regs done");
  endtask

  task automatic t_run_out;
    ports <= 24'h332211;
    wr(8'h00, 32'h9);
    wr(8'h04, 32'h1);
    wt(0, 1'b1, 4);
    chk(emu_oe_n, 1'b1, "released at run");
    cyc(1);
    chk(lamps, 3'h3, "run lamps");
    wr(8'h04, 32'h4);
    wt(1, 1'b1, 3);
    wt(3, 1'b1, 20);
    chk(trace_data, 24'h332211, "frame ports");
    wr(8'h04, 32'h8);
    wt(1, 1'b0, 3);
    wr(8'h04, 32'h2);
    wt(0, 1'b0, 4);
    chk(emu_oe_n, 1'b0, "low at halt");
    cyc(1);
    chk(lamps, 3'h1, "idle again");
    $display("run out done");
  endtask

  // hold-off, wait lamp, halt from the line
  task automatic t_hold;
    time t0;
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h1);
    t0 = $time;
    wt(4, 1'b1, 3);
    chk(lamps, 3'h2, "waiting lamp");
    wt(0, 1'b1, 2000);
    chk(($time - t0) >= HOLD * 100, 1'b1, "hold-off");
    emu_req <= 1'b1;
    wt(0, 1'b0, 16);
    emu_req <= 1'b0;
    cyc(30);
    $display("hold done");
  endtask

  // latched input waits for a strobe edge
  task automatic t_latch;
    wr(8'h00, 32'h4);
    wr(8'h04, 32'h1);
    wt(0, 1'b1, 2000);
    stb_en <= 1'b0;
    emu_req <= 1'b1;
    cyc(20);
    chk(emulating, 1'b1, "no strobe no halt");
    stb_en <= 1'b1;
    wt(0, 1'b0, 16);
    emu_req <= 1'b0;
    cyc(30);
    $display("latch done");
  endtask

  // trace follows the trace line level
  task automatic t_trc_in;
    wr(8'h00, 32'h10);
    cyc(10);
    rdr(8'h08);
    chk(rd[1], 1'b1, "trace on high");
    trc_req <= 1'b1;
    cyc(8);
    rdr(8'h08);
    chk(rd[1], 1'b0, "trace off low");
    trc_req <= 1'b0;
    cyc(30);
    rdr(8'h08);
    chk(rd[1], 1'b1, "trace on again");
    $display("trace in done");
  endtask

  task automatic lmp(input logic [8:0] c, input logic [2:0] e);
    wr(8'h04, {23'h0, c});
    cyc(2);
    chk(lamps, e, "lamps");
  endtask

  task automatic t_lamps;
    wr(8'h00, 32'h0);
    lmp(9'h080, 3'h4);
    lmp(9'h100, 3'h5);
    lmp(9'h020, 3'h0);
    lmp(9'h040, 3'h1);
    lmp(9'h010, 3'h5);
    cyc(20);
    chk(lamps, 3'h1, "reinit over");
    $display("lamps done");
  endtask

  // break with supply lost and near breakpoints
  task automatic t_break;
    wr(8'h0C, 32'h100);
    wr(8'h10, 32'h103);
    wr(8'h04, 32'h1);
    wt(0, 1'b1, 4);
    {vcc_ok, clk_ok} <= 2'h0;
    cyc(10);
    chk(emulating, 1'b1, "runs unpowered");
    tmr_run <= 1'b1;
    bp0_hit <= 1'b1;
    brk <= 1'b1;
    wt(2, 1'b1, 4);
    chk(emulating, 1'b0, "break halts");
    brk <= 1'b0;
    tmr_run <= 1'b0;
    bp0_hit <= 1'b0;
    cyc(1);
    chk(timer_extra_count, 1'b0, "single count");
    rdr(8'h08);
    chk(rd[14:9], 6'h3B, "cause and supply");
    {vcc_ok, clk_ok} <= 2'h3;
    rst_pin <= 1'b1;
    cyc(6);
    wr(8'h08, 32'h600);
    rdr(8'h08);
    chk(rd[11:9], 3'h4, "reset flag, supply cleared");
    $display("break done");
  endtask

  // qualified trace, frames added by an interrupt at break
  task automatic t_qual;
    wr(8'h00, 32'h40);
    wr(8'h04, 32'h4);
    wr(8'h04, 32'h1);
    wt(0, 1'b1, 4);
    frames(16, 0, "no frame before qualifier");
    irq <= 1'b1;
    brk <= 1'b1;
    wt(0, 1'b0, 4);
    irq <= 1'b0;
    brk <= 1'b0;
    frames(40, 4, "extra frames after break");
    qev <= 1'b1;
    cyc(1);
    qev <= 1'b0;
    cyc(4);
    frames(16, 4, "frames after qualifier");
    $display("qual done");
  endtask

  // watchdog on the whole run
  initial begin
    cyc(60000);
    err_total++;
    $display("[FAIL] %0t run too long", $time);
    stop_test;
  end

  // main sequence
  initial begin
    {hresetn, hwrite, emu_req, trc_req, rst_pin, brk} = 6'h0;
    {bp0_hit, tmr_run, irq, qev, stb_cnt} = 6'h00;
    {hsel, vcc_ok, clk_ok, stb_en} = 4'hF;
    htrans = 2'h0;
    haddr = 8'h00;
    hwdata = 32'h0;
    ports = 24'h0;
    err_total = 0;
    compares = 0;
    cyc(2);
    hresetn <= 1'b1;
    cyc(4);
    t_regs;
    t_run_out;
    t_hold;
    t_latch;
    t_trc_in;
    t_lamps;
    t_break;
    t_qual;
    stop_test;
  end
endmodule
`default_nettype wire
